/* hdl/sdsi_pkg.sv */
// sdsi_pkg: constants, register map and state types of the switch/dim sensor input
// assumes a 125 MHz system clock and a plain address/strobe register port
package sdsi_pkg;

    // clock and time base
    localparam int CLK_FREQ_HZ = 125_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYC_PER_MS = CLK_FREQ_HZ / MS_PER_S;
    localparam int CYCLIC_MS = 60000;

    // register port
    localparam int AW = 3;
    localparam int DW = 16;
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_CFG = 3'h1;
    localparam logic [2:0] ADDR_TIME = 3'h2;
    localparam logic [2:0] ADDR_SWITCH = 3'h3;
    localparam logic [2:0] ADDR_STATUS = 3'h4;

    // control register bits
    localparam int CTRL_BLOCK = 0;
    localparam int CTRL_MAN_EN = 1;
    localparam int CTRL_MAN_LVL = 2;
    localparam logic [15:0] CTRL_RST = 16'h0000;

    // configuration register fields
    localparam int CFG_DB_LSB = 0;
    localparam int CFG_OPEN = 3;
    localparam int CFG_ONLY_DIM = 4;
    localparam int CFG_SHORT_LSB = 5;
    localparam int CFG_DIR_LSB = 7;
    localparam int CFG_STEPPED = 10;
    localparam int CFG_STEP_LSB = 11;
    localparam int CFG_CYC_EN = 14;
    localparam logic [15:0] CFG_RST = 16'h1a43;

    // timing register fields
    localparam int TIME_LONG_LSB = 0;
    localparam int TIME_REP_LSB = 8;
    localparam logic [15:0] TIME_RST = 16'h0101;

    // short reaction codes
    localparam logic [1:0] SHORT_ON = 2'h0;
    localparam logic [1:0] SHORT_OFF = 2'h1;
    localparam logic [1:0] SHORT_TOGGLE = 2'h2;
    localparam logic [1:0] SHORT_NONE = 2'h3;

    // dimming direction codes
    localparam logic [2:0] DIR_BRIGHTER = 3'h0;
    localparam logic [2:0] DIR_DARKER = 3'h1;
    localparam logic [2:0] DIR_ALT = 3'h2;
    localparam logic [2:0] DIR_ALT_BR_ON = 3'h3;
    localparam logic [2:0] DIR_ALT_DK_ON = 3'h4;

    // dimming command layout
    localparam int CMD_DIR = 3;
    localparam logic [2:0] STEP_STOP = 3'h0;
    localparam logic [2:0] STEP_FULL = 3'h1;

    // time tables in ms
    localparam logic [7:0] DB_MS [0:6] = '{8'd10, 8'd20, 8'd30, 8'd50, 8'd70, 8'd100, 8'd150};
    localparam logic [15:0] LONG_MS [0:16] = '{16'd300, 16'd400, 16'd500, 16'd600, 16'd800,
        16'd1000, 16'd1200, 16'd1500, 16'd2000, 16'd3000, 16'd4000, 16'd5000, 16'd6000,
        16'd7000, 16'd8000, 16'd9000, 16'd10000};

    typedef enum logic [1:0] {PS_IDLE, PS_HOLD, PS_DIM} sdsi_ps_t;

    typedef struct packed {
        logic [1:0] sync;
        logic [15:0] ctrl;
        logic [15:0] cfg;
        logic [15:0] tim;
        logic sw;
        logic on_first;
        logic last_dir;
        logic [3:0] cmd;
        logic stable;
        logic [16:0] pre;
        logic [7:0] db_cnt;
        logic db_busy;
        logic [15:0] hold_cnt;
        logic [15:0] rep_cnt;
        logic [15:0] cyc_cnt;
        sdsi_ps_t ps;
        logic sw_send;
        logic dim_send;
        logic [15:0] rdata;
    } sdsi_st_t;

endpackage

/* hdl/sdsi_top.sv */
// sdsi_top: one push-button input evaluated as switch/dim sensor
// assumes CONTACT_I is an asynchronous pin, level high means contact closed
`timescale 1ns/1ps

module sdsi_top
    import sdsi_pkg::*;
#(
    parameter int MS_CYC = CYC_PER_MS,
    parameter int CYCLIC_PERIOD_MS = CYCLIC_MS
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RSTN_I,
    // contact pin
    input wire logic CONTACT_I,
    // register port
    input wire logic [AW-1:0] ADDR_I,
    input wire logic [DW-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [DW-1:0] RDATA_O,
    // telegrams toward the bus
    output logic SW_VAL_O,
    output logic SW_SEND_O,
    output logic [3:0] DIM_CMD_O,
    output logic DIM_SEND_O
);

    sdsi_st_t st_reg;
    sdsi_st_t st_next;

    function automatic logic pick_dir(input logic sw, input logic last, input logic [2:0] mode,
                                      input logic first);
        logic d;
        d = ~last;
        if (mode == DIR_BRIGHTER) begin
            d = 1'b1;
        end else if (mode == DIR_DARKER) begin
            d = 1'b0;
        end else if (!sw) begin
            d = 1'b1;
        end else if (first && mode == DIR_ALT_BR_ON) begin
            d = 1'b1;
        end else if (first && mode == DIR_ALT_DK_ON) begin
            d = 1'b0;
        end
        return d;
    endfunction

    always_comb begin
        logic tick;
        logic frozen;
        logic raw;
        logic act;
        logic press;
        logic rel;
        logic start_dim;
        logic d;
        logic [7:0] db_ms;
        logic [15:0] long_ms;
        logic [15:0] rep_ms;
        logic [2:0] db_sel;
        logic [4:0] long_sel;
        logic [4:0] rep_sel;
        logic [2:0] step;
        tick = 1'b0;
        frozen = 1'b0;
        raw = 1'b0;
        act = 1'b0;
        press = 1'b0;
        rel = 1'b0;
        start_dim = 1'b0;
        d = 1'b0;
        db_ms = '0;
        long_ms = '0;
        rep_ms = '0;
        db_sel = '0;
        long_sel = '0;
        rep_sel = '0;
        step = '0;
        st_next = st_reg;
        st_next.sw_send = 1'b0;
        st_next.dim_send = 1'b0;
        st_next.rdata = '0;
        st_next.sync = {st_reg.sync[0], CONTACT_I};
        // millisecond time base
        tick = (st_reg.pre == 17'(MS_CYC - 1));
        st_next.pre = tick ? '0 : st_reg.pre + 17'd1;
        // table lookups
        db_sel = st_reg.cfg[CFG_DB_LSB +: 3];
        db_ms = (db_sel > 3'd6) ? DB_MS[6] : DB_MS[db_sel];
        long_sel = st_reg.tim[TIME_LONG_LSB +: 5];
        long_ms = (long_sel > 5'd16) ? LONG_MS[16] : LONG_MS[long_sel];
        rep_sel = st_reg.tim[TIME_REP_LSB +: 5];
        rep_ms = (rep_sel > 5'd16) ? LONG_MS[16] : LONG_MS[rep_sel];
        step = (st_reg.cfg[CFG_STEP_LSB +: 3] > 3'd6) ? 3'd7
             : st_reg.cfg[CFG_STEP_LSB +: 3] + 3'd1;
        // input source and polarity
        frozen = st_reg.ctrl[CTRL_BLOCK] && !st_reg.ctrl[CTRL_MAN_EN];
        raw = st_reg.ctrl[CTRL_MAN_EN] ? st_reg.ctrl[CTRL_MAN_LVL] : st_reg.sync[1];
        act = st_reg.cfg[CFG_OPEN] ? ~raw : raw;
        // debounce
        if (st_reg.db_busy) begin
            if (tick) begin
                st_next.db_cnt = st_reg.db_cnt + 8'd1;
                if (st_reg.db_cnt + 8'd1 >= db_ms) begin
                    st_next.db_busy = 1'b0;
                end
            end
        end else if (!frozen && act != st_reg.stable) begin
            st_next.stable = act;
            st_next.db_busy = 1'b1;
            st_next.db_cnt = '0;
            press = act;
            rel = ~act;
        end
        d = pick_dir(st_reg.sw, st_reg.last_dir, st_reg.cfg[CFG_DIR_LSB +: 3], st_reg.on_first);
        // actuation evaluation
        case (st_reg.ps)
            PS_IDLE: begin
                if (press) begin
                    if (st_reg.cfg[CFG_ONLY_DIM]) begin
                        start_dim = 1'b1;
                    end else begin
                        st_next.ps = PS_HOLD;
                        st_next.hold_cnt = '0;
                    end
                end
            end
            PS_HOLD: begin
                if (rel) begin
                    st_next.ps = PS_IDLE;
                    case (st_reg.cfg[CFG_SHORT_LSB +: 2])
                        SHORT_ON: begin
                            st_next.sw = 1'b1;
                            st_next.sw_send = 1'b1;
                        end
                        SHORT_OFF: begin
                            st_next.sw = 1'b0;
                            st_next.sw_send = 1'b1;
                        end
                        SHORT_TOGGLE: begin
                            st_next.sw = ~st_reg.sw;
                            st_next.sw_send = 1'b1;
                        end
                        default: begin
                            st_next.sw = st_reg.sw;
                        end
                    endcase
                end else if (st_reg.hold_cnt >= long_ms) begin
                    start_dim = 1'b1;
                end else if (tick && !frozen) begin
                    st_next.hold_cnt = st_reg.hold_cnt + 16'd1;
                end
            end
            PS_DIM: begin
                if (rel) begin
                    st_next.ps = PS_IDLE;
                    if (!st_reg.cfg[CFG_STEPPED]) begin
                        st_next.cmd = {st_reg.last_dir, STEP_STOP};
                        st_next.dim_send = 1'b1;
                    end
                end else if (st_reg.cfg[CFG_STEPPED] && tick && !frozen) begin
                    if (st_reg.rep_cnt + 16'd1 >= rep_ms) begin
                        st_next.rep_cnt = '0;
                        st_next.dim_send = 1'b1;
                    end else begin
                        st_next.rep_cnt = st_reg.rep_cnt + 16'd1;
                    end
                end
            end
            default: begin
                st_next.ps = PS_IDLE;
            end
        endcase
        if (start_dim) begin
            st_next.ps = PS_DIM;
            st_next.last_dir = d;
            st_next.on_first = 1'b0;
            st_next.rep_cnt = '0;
            st_next.cmd = {d, st_reg.cfg[CFG_STEPPED] ? step : STEP_FULL};
            st_next.dim_send = 1'b1;
        end
        // cyclic sending of the switch state, independent of block
        if (st_reg.cfg[CFG_CYC_EN]) begin
            if (tick) begin
                if (st_reg.cyc_cnt + 16'd1 >= 16'(CYCLIC_PERIOD_MS)) begin
                    st_next.cyc_cnt = '0;
                    st_next.sw_send = 1'b1;
                end else begin
                    st_next.cyc_cnt = st_reg.cyc_cnt + 16'd1;
                end
            end
        end else begin
            st_next.cyc_cnt = '0;
        end
        // register writes
        if (WR_I) begin
            case (ADDR_I)
                ADDR_CTRL: st_next.ctrl = WDATA_I & 16'h0007;
                ADDR_CFG: st_next.cfg = WDATA_I & 16'h7fff;
                ADDR_TIME: st_next.tim = WDATA_I & 16'h1f1f;
                ADDR_SWITCH: st_next.sw = WDATA_I[0];
                default: st_next.ctrl = st_next.ctrl;
            endcase
        end
        // a rising switch value arms the after-ON direction
        if (st_next.sw && !st_reg.sw) begin
            st_next.on_first = 1'b1;
        end
        // register reads
        if (RD_I) begin
            case (ADDR_I)
                ADDR_CTRL: st_next.rdata = st_reg.ctrl;
                ADDR_CFG: st_next.rdata = st_reg.cfg;
                ADDR_TIME: st_next.rdata = st_reg.tim;
                ADDR_SWITCH: st_next.rdata = {15'h0000, st_reg.sw};
                ADDR_STATUS: st_next.rdata = {4'h0, st_reg.ps, frozen, st_reg.stable,
                                              st_reg.cmd, st_reg.on_first, st_reg.last_dir,
                                              st_reg.db_busy, st_reg.sw};
                default: st_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            st_reg <= '0;
            st_reg.ctrl <= CTRL_RST;
            st_reg.cfg <= CFG_RST;
            st_reg.tim <= TIME_RST;
            st_reg.ps <= PS_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign RDATA_O = st_reg.rdata;
    assign SW_VAL_O = st_reg.sw;
    assign SW_SEND_O = st_reg.sw_send;
    assign DIM_CMD_O = st_reg.cmd;
    assign DIM_SEND_O = st_reg.dim_send;

endmodule // sdsi_top

/* sim/sdsi_top_properties.sv */
// sdsi_top_chk: port relations of the switch/dim sensor input
// assumes the register map and field layout of sdsi_pkg
`timescale 1ns/1ps
module sdsi_top_chk
    import sdsi_pkg::*;
#(
    parameter int MS_CYC = CYC_PER_MS,
    parameter int CYCLIC_PERIOD_MS = CYCLIC_MS
) (
    // clock, reset, pin
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic CONTACT_I,
    // register port
    input wire logic [AW-1:0] ADDR_I,
    input wire logic [DW-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [DW-1:0] RDATA_O,
    // telegrams
    input wire logic SW_VAL_O,
    input wire logic SW_SEND_O,
    input wire logic [3:0] DIM_CMD_O,
    input wire logic DIM_SEND_O
);
    logic [15:0] cfg_q;
    default clocking dc @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    // shadow of the configuration register
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cfg_q <= CFG_RST;
        end else if (WR_I && ADDR_I == ADDR_CFG) begin
            cfg_q <= WDATA_I;
        end
    end
    sequence sw_wr_s;
        WR_I && ADDR_I == ADDR_SWITCH;
    endsequence
    sequence dim_go_s;
        DIM_SEND_O && DIM_CMD_O[2:0] != STEP_STOP;
    endsequence
    sw_write_a: assert property (sw_wr_s |=> SW_VAL_O == $past(WDATA_I[0]))
        else $error("switch write lost");
    sw_read_a: assert property (RD_I && ADDR_I == ADDR_SWITCH |=> RDATA_O[0] == $past(SW_VAL_O))
        else $error("switch readback wrong");
    sw_cause_a: assert property ($changed(SW_VAL_O) |-> SW_SEND_O || $past(WR_I))
        else $error("switch value changed silently");
    dim_cause_a: assert property ($changed(DIM_CMD_O) |-> DIM_SEND_O)
        else $error("dim command changed silently");
    dim_pulse_a: assert property (DIM_SEND_O |=> !DIM_SEND_O [*3])
        else $error("dim send too long");
    dim_dir_a: assert property (DIM_SEND_O && cfg_q[9:8] == 2'h0 |-> DIM_CMD_O[3] == !cfg_q[7])
        else $error("fixed direction wrong");
    dim_step_a: assert property (DIM_SEND_O && cfg_q[CFG_STEPPED] |-> DIM_CMD_O[2:0] == cfg_q[13:11] + 3'h1)
        else $error("step code wrong");
    dim_ss_a: assert property (DIM_SEND_O && !cfg_q[CFG_STEPPED] |-> DIM_CMD_O[2:0] <= STEP_FULL)
        else $error("start stop code wrong");
    dim_alt_a: assert property (dim_go_s ##0 (!SW_VAL_O && cfg_q[9:7] >= DIR_ALT) |-> DIM_CMD_O[3])
        else $error("switch off not brighter");
endmodule // sdsi_top_chk

bind sdsi_top sdsi_top_chk #(.MS_CYC(MS_CYC), .CYCLIC_PERIOD_MS(CYCLIC_PERIOD_MS)) chk_u (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .CONTACT_I(CONTACT_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .SW_VAL_O(SW_VAL_O),
    .SW_SEND_O(SW_SEND_O), .DIM_CMD_O(DIM_CMD_O), .DIM_SEND_O(DIM_SEND_O));

/* sim/sdsi_contact_model.sv */
// sdsi_contact_model: push button with contact bounce
// assumes a closed contact reads high on the pin
`timescale 1ns/1ps
module sdsi_contact_model (
    // clock
    input wire logic clk_i,
    // button state and pin
    input wire logic press_i,
    output logic contact_o
);
    logic lvl_reg = 1'b0;
    logic [2:0] bnc_reg = 3'h0;
    always @(posedge clk_i) begin
        if (press_i != lvl_reg) begin
            lvl_reg <= press_i;
            bnc_reg <= 3'h6;
        end else if (bnc_reg != 3'h0) begin
            bnc_reg <= bnc_reg - 3'h1;
        end
    end
    // bounces three times after each change, closed drives high
    assign contact_o = lvl_reg ^ bnc_reg[0];
endmodule // sdsi_contact_model

/* sim/sdsi_top_tb.sv */
// sdsi_top_tb: register tasks and button actuations with telegram checks
// assumes 10 cycles per ms and a bouncing closed contact on the pin
`timescale 1ns/1ps
module sdsi_top_tb;
    import sdsi_pkg::*;
    localparam int SHORT = 300;
    localparam int LONG = 3400;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic press = 1'b0;
    logic contact;
    logic [AW-1:0] addr = '0;
    logic [DW-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [DW-1:0] rdata;
    logic sw_val;
    logic sw_send;
    logic [3:0] dim_cmd;
    logic dim_send;
    logic [3:0] cmdq[$];
    int n_sw = 0;
    int s0;
    int n_mismatch = 0;
    int num_checks = 0;
    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (sw_send) n_sw <= n_sw + 1;
        if (dim_send) cmdq.push_back(dim_cmd);
    end
    sdsi_contact_model btn_u (.clk_i(clk), .press_i(press), .contact_o(contact));
    sdsi_top #(.MS_CYC(10), .CYCLIC_PERIOD_MS(5)) dut_u (
        .CLK_I(clk), .RSTN_I(rstn), .CONTACT_I(contact), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SW_VAL_O(sw_val), .SW_SEND_O(sw_send),
        .DIM_CMD_O(dim_cmd), .DIM_SEND_O(dim_send));
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a, input logic [15:0] exp, input string nm);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, exp, rdata);
    endtask
    task automatic step(input int hold, input int dsw, input logic v, input int nq,
                        input logic [3:0] c0, input logic [3:0] c1);
        s0 = n_sw;
        cmdq.delete();
        @(posedge clk);
        press <= 1'b1;
        repeat (hold) @(posedge clk);
        press <= 1'b0;
        repeat (400) @(posedge clk);
        #1;
        chk("switch sends", 16'(dsw), 16'(n_sw - s0));
        chk("switch value", {15'h0, v}, {15'h0, sw_val});
        chk("dim sends", 16'(nq), 16'(cmdq.size()));
        if (nq > 0) chk("first dim", {12'h0, c0}, {12'h0, cmdq[0]});
        if (nq > 1) chk("second dim", {12'h0, c1}, {12'h0, cmdq[1]});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(ADDR_CTRL, 16'h0000, "ctrl reset");
        rd_reg(ADDR_CFG, 16'h1a43, "cfg reset");
        rd_reg(ADDR_TIME, 16'h0101, "time reset");
        rd_reg(3'h6, 16'h0000, "unmapped read");
        wr_reg(ADDR_CFG, 16'h1240);
        wr_reg(ADDR_TIME, 16'h0000);
        step(SHORT, 1, 1'b1, 0, 4'h0, 4'h0);
        step(LONG, 0, 1'b1, 2, 4'h1, 4'h0);
        step(LONG, 0, 1'b1, 2, 4'h9, 4'h8);
        wr_reg(ADDR_SWITCH, 16'h0000);
        step(LONG, 0, 1'b0, 2, 4'h9, 4'h8);
        wr_reg(ADDR_CFG, 16'h11c0);
        step(SHORT, 1, 1'b1, 0, 4'h0, 4'h0);
        step(LONG, 0, 1'b1, 2, 4'h9, 4'h8);
        step(LONG, 0, 1'b1, 2, 4'h1, 4'h0);
        for (int k = 0; k < 4; k++) begin
            wr_reg(ADDR_CFG, 16'h1000 | 16'(k * 32 + (k % 2) * 128));
            step(SHORT, (k < 3) ? 1 : 0, k != 1, 0, 4'h0, 4'h0);
            step(LONG, 0, k != 1, 2, {~k[0], 3'h1}, {~k[0], 3'h0});
        end
        wr_reg(ADDR_CFG, 16'h1010);
        cmdq.delete();
        press <= 1'b1;
        repeat (20) @(posedge clk);
        #1;
        chk("only dim count", 16'h1, 16'(cmdq.size()));
        chk("only dim cmd", 16'h9, {12'h0, cmdq[0]});
        @(posedge clk);
        press <= 1'b0;
        repeat (400) @(posedge clk);
        wr_reg(ADDR_CFG, 16'h1480);
        wr_reg(ADDR_TIME, 16'h0100);
        step(8000, 0, 1'b1, 2, 4'h3, 4'h3);
        wr_reg(ADDR_CTRL, 16'h0001);
        step(SHORT, 0, 1'b1, 0, 4'h0, 4'h0);
        s0 = n_sw;
        wr_reg(ADDR_CTRL, 16'h0007);
        repeat (SHORT) @(posedge clk);
        wr_reg(ADDR_CTRL, 16'h0003);
        repeat (400) @(posedge clk);
        #1;
        chk("manual sends", 16'h1, 16'(n_sw - s0));
        chk("manual value", 16'h1, {15'h0, sw_val});
        wr_reg(ADDR_CTRL, 16'h0001);
        wr_reg(ADDR_CFG, 16'h5480);
        s0 = n_sw;
        repeat (260) @(posedge clk);
        #1;
        chk("cyclic while blocked", 16'h1, 16'(n_sw - s0 >= 4));
        rd_reg(ADDR_SWITCH, 16'h0001, "switch readback");
        summarize();
    end
endmodule // sdsi_top_tb
